// >>> inc/pac_pkg.sv
// package for the programming adapter control block: types and constants
// assumes a 200 MHz system clock and buttons that read high when pressed
package pac_pkg;

  // clock rate in kHz
  localparam int unsigned CLK_KHZ = 200_000;
  // debounce time in ms and its cycle count
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  // target reset pulse length in us and cycles
  localparam int unsigned RST_PULSE_US = 100;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * (CLK_KHZ / 1000);
  // loop-back hold after reset release, in ms and cycles
  localparam int unsigned LOOP_HOLD_MS = 50;
  localparam int unsigned LOOP_HOLD_CYC = LOOP_HOLD_MS * CLK_KHZ;
  // button index positions
  localparam int unsigned BTN_RESET = 0;
  localparam int unsigned BTN_TRACE = 1;
  localparam int unsigned BTN_MODE = 2;
  localparam int unsigned BTN_VPP = 3;
  localparam int unsigned BTN_COUNT = 4;

  // host receive routing
  typedef enum logic [1:0] {
    PAC_ROUTE_RX = 2'h0,   // host rx follows target receive pin
    PAC_ROUTE_TX = 2'h1,   // host rx follows target transmit pin
    PAC_ROUTE_THRU = 2'h2  // host rx/tx wired to target tx/rx
  } pac_route_t;

  // reset sequencer states, one-hot
  typedef enum logic [2:0] {
    PAC_SEQ_IDLE = 3'h1,
    PAC_SEQ_PULSE = 3'h2,
    PAC_SEQ_HOLD = 3'h4
  } pac_seq_t;

  // adapter status bundle
  typedef struct packed {
    logic boot_mode;      // boot mode selected
    logic loop_back;      // target pins looped together
    logic vpp_on;         // programming voltage enabled
    pac_route_t route;    // monitor routing
  } pac_status_t;

  // reset values
  localparam logic RST_BOOT_MODE = 1'b0;
  localparam logic RST_VPP_ON = 1'b0;
  localparam pac_route_t RST_ROUTE = PAC_ROUTE_RX;

endpackage

// >>> rtl/pac_debounce.sv
// one debounced button: three-flop sync plus a hold timer
// assumes a raw asynchronous pin, high when pressed
`timescale 1ns/1ps
module pac_debounce #(
  parameter int unsigned HOLD_CYC = pac_pkg::DEBOUNCE_CYC
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // raw pin
  input wire logic pin_raw,
  // clean level and release pulse
  output logic level,
  output logic released
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  // synchroniser chain; sync1 read only by sync2
  logic sync1;
  logic sync2;
  logic sync3;
  // hold counter after an accepted edge
  logic [CW-1:0] hold;

  // agreeing stages mark a real change
  wire changed = (sync2 == sync3) && (sync3 != level);
  wire hold_busy = (hold != '0);

  // sync chain
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (clk_en) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // accept an edge, then ignore the pin for the hold time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level <= 1'b0;
      released <= 1'b0;
      hold <= '0;
    end else if (clk_en) begin
      released <= 1'b0;
      if (hold_busy) begin
        hold <= hold - CW'(1);
      end else if (changed) begin
        level <= sync3;
        released <= level; // fall of clean level
        hold <= CW'(HOLD_CYC);
      end
    end
  end
endmodule // pac_debounce

// >>> rtl/pac_adapter.sv
// programming adapter control: buttons, mode, vpp, routing, reset sequence
// assumes raw button pins high when pressed and a shared open-drain reset
`timescale 1ns/1ps
module pac_adapter #(
  parameter int unsigned DEBOUNCE_CYC = pac_pkg::DEBOUNCE_CYC,
  parameter int unsigned RST_PULSE_CYC = pac_pkg::RST_PULSE_CYC,
  parameter int unsigned LOOP_HOLD_CYC = pac_pkg::LOOP_HOLD_CYC
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // raw push buttons
  input wire logic target_reset_button,
  input wire logic serial_trace_button,
  input wire logic mode_toggle_button,
  input wire logic prog_voltage_button,
  // shared target reset line, open drain
  input wire logic target_reset_n_in,
  output logic target_reset_n_out,
  output logic target_reset_n_oe,
  // boot mode select pins, open drain
  output logic boot_mode_select_pins_out,
  output logic boot_mode_select_pins_oe,
  // serial lines
  input wire logic target_transmit_pin,
  input wire logic host_tx,
  output logic host_rx,
  output logic target_receive_pin_out,
  output logic target_receive_pin_oe,
  input wire logic target_receive_pin_in,
  // programming voltage enable
  output logic programming_voltage,
  // status
  output pac_pkg::pac_status_t status
);
  // counter widths, wide enough for the loaded cycle count
  localparam int unsigned PW = $clog2(RST_PULSE_CYC + 1);
  localparam int unsigned LW = $clog2(LOOP_HOLD_CYC + 1);

  // next routing in the three-state cycle
  // the three routes form a ring stepped by the trace button
  // wraps from feed-through back to the receive-pin tap
  function automatic pac_pkg::pac_route_t route_step(
    input pac_pkg::pac_route_t r
  );
    unique case (r)
      pac_pkg::PAC_ROUTE_RX: route_step = pac_pkg::PAC_ROUTE_TX;
      pac_pkg::PAC_ROUTE_TX: route_step = pac_pkg::PAC_ROUTE_THRU;
      default: route_step = pac_pkg::PAC_ROUTE_RX;
    endcase
  endfunction

  // raw and debounced buttons
  // index order follows the button positions in the package
  wire [pac_pkg::BTN_COUNT-1:0] btn_raw = {prog_voltage_button,
    mode_toggle_button, serial_trace_button, target_reset_button};
  logic [pac_pkg::BTN_COUNT-1:0] btn_rel;

  // one debouncer per button
  // each button has its own sync chain and hold timer
  // only the release pulse is used; actions wait for release
  genvar gi;
  for (gi = 0; gi < pac_pkg::BTN_COUNT; gi++) begin : g_btn
    pac_debounce #(.HOLD_CYC(DEBOUNCE_CYC)) u_db (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin_raw(btn_raw[gi]),
      .level(),
      .released(btn_rel[gi])
    );
  end

  // reset line synchroniser, three flops
  // reset value 1 matches the idle, pulled-up line, so no
  // false falling edge follows sys_rst
  logic rl1;
  logic rl2;
  logic rl3;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rl1 <= 1'b1;
      rl2 <= 1'b1;
      rl3 <= 1'b1;
    end else if (clk_en) begin
      rl1 <= target_reset_n_in;
      rl2 <= rl1;
      rl3 <= rl2;
    end
  end
  // clean reset level, changes once stages two and three agree
  // our own pull shows up here too; the sequencer is busy then
  logic rl_level;
  wire rl_agree = (rl2 == rl3);
  wire rl_fall = rl_agree && !rl3 && rl_level;
  wire rl_rise = rl_agree && rl3 && !rl_level;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) rl_level <= 1'b1;
    else if (clk_en && rl_agree) rl_level <= rl3;
  end

  // mode, vpp and routing state
  // mode and vpp survive a target reset; only sys_rst clears them
  logic boot_mode;
  logic vpp_on;
  pac_pkg::pac_route_t route;

  // button actions, trace and vpp gated by mode
  // presses in the wrong mode are dropped silently
  wire rst_press = btn_rel[pac_pkg::BTN_RESET];
  wire trace_go = btn_rel[pac_pkg::BTN_TRACE] && !boot_mode;
  wire mode_go = btn_rel[pac_pkg::BTN_MODE];
  wire vpp_go = btn_rel[pac_pkg::BTN_VPP] && boot_mode;

  // mode, vpp, routing registers
  // clk_en low freezes every register below
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_mode <= pac_pkg::RST_BOOT_MODE;
      vpp_on <= pac_pkg::RST_VPP_ON;
      route <= pac_pkg::RST_ROUTE;
    end else if (clk_en) begin
      if (mode_go) boot_mode <= !boot_mode;
      if (vpp_go) vpp_on <= !vpp_on;
      if (trace_go) route <= route_step(route);
    end
  end

  // reset sequencer
  // pulse_cnt times our own pull, hold_cnt the loop-back tail
  pac_pkg::pac_seq_t seq;
  pac_pkg::pac_seq_t next_seq;
  logic [PW-1:0] pulse_cnt;
  logic [LW-1:0] hold_cnt;
  logic loop_back;
  logic drive_rst;

  // sequence triggers: button press or foreign falling edge
  // a stale trigger cannot queue: seq_start needs the idle state
  // the pulse state ends only once the line reads high again, so a
  // board that keeps reset low stretches the sequence
  wire seq_idle = (seq == pac_pkg::PAC_SEQ_IDLE);
  wire seq_start = seq_idle && (rst_press || rl_fall);
  wire pulse_done = (pulse_cnt == '0) && rl_rise;
  wire hold_done = (hold_cnt == '0);

  // next state
  always_comb begin
    next_seq = seq;
    unique case (seq)
      pac_pkg::PAC_SEQ_IDLE: begin
        // wait for a release or a foreign reset edge
        if (seq_start) next_seq = pac_pkg::PAC_SEQ_PULSE;
      end
      pac_pkg::PAC_SEQ_PULSE: begin
        // boot mode keeps the loop for the hold time
        if (pulse_done) begin
          next_seq = boot_mode ? pac_pkg::PAC_SEQ_HOLD
                               : pac_pkg::PAC_SEQ_IDLE;
        end
      end
      pac_pkg::PAC_SEQ_HOLD: begin
        // hold timer runs out, feed-through from here
        if (hold_done) next_seq = pac_pkg::PAC_SEQ_IDLE;
      end
      default: next_seq = pac_pkg::PAC_SEQ_IDLE;
    endcase
  end

  // state, counters, drive and loop-back
  // pulse_cnt reloads on start, hold_cnt at pulse end; triggers while busy are ignored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq <= pac_pkg::PAC_SEQ_IDLE;
      pulse_cnt <= '0;
      hold_cnt <= '0;
      loop_back <= 1'b0;
      drive_rst <= 1'b0;
    end else if (clk_en) begin
      seq <= next_seq;
      if (seq_start) begin
        pulse_cnt <= PW'(RST_PULSE_CYC);
        drive_rst <= 1'b1;
        loop_back <= boot_mode;
      end else if (seq == pac_pkg::PAC_SEQ_PULSE) begin
        // count down, then let go of the line
        if (pulse_cnt != '0) pulse_cnt <= pulse_cnt - PW'(1);
        else drive_rst <= 1'b0;
        if (pulse_done) begin
          hold_cnt <= LW'(LOOP_HOLD_CYC);
          if (!boot_mode) loop_back <= 1'b0;
        end
      end else if (seq == pac_pkg::PAC_SEQ_HOLD) begin
        if (!hold_done) hold_cnt <= hold_cnt - LW'(1);
        else loop_back <= 1'b0;
      end
    end
  end

  // routing selection
  // host receive taps the target transmit pin in boot mode, in the
  // transmit route and in feed-through; else the receive pin
  wire thru = !boot_mode && (route == pac_pkg::PAC_ROUTE_THRU);
  wire rx_sel_tx = boot_mode || (route != pac_pkg::PAC_ROUTE_RX);
  wire next_host_rx = rx_sel_tx ? target_transmit_pin
                                : target_receive_pin_in;
  // host receive flop
  // registered, so host_rx lags the pins by one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) host_rx <= 1'b1;
    else if (clk_en) host_rx <= next_host_rx;
  end

  // pin drives
  // open-drain style: out stays 0 and oe decides
  assign target_reset_n_out = 1'b0;
  assign target_reset_n_oe = drive_rst;
  assign boot_mode_select_pins_out = 1'b0;
  assign boot_mode_select_pins_oe = boot_mode;
  // loop-back takes priority; else feed-through in boot or thru route
  // feed-through hands the target receive pin to the host
  assign target_receive_pin_oe = loop_back || boot_mode || thru;
  assign target_receive_pin_out = loop_back ? target_transmit_pin
                                            : host_tx;
  assign programming_voltage = vpp_on;
  assign status = '{boot_mode: boot_mode, loop_back: loop_back,
                    vpp_on: vpp_on, route: route};
endmodule // pac_adapter

// >>> sim/pac_target_model.sv
// target board model: pulled-up reset line, receive pin shared by resistor
// assumes adapter drives the receive pin only while its enable is high
`timescale 1ns/1ps
module pac_target_model (
  // reset line pullers
  input wire logic rst_pull,
  input wire logic board_rst,
  // receive pin drivers
  input wire logic rx_oe,
  input wire logic rx_out,
  input wire logic board_rx,
  // resolved pins
  output logic reset_line,
  output logic rx_pin
);
  // open drain with pull-up: low if anyone pulls
  assign reset_line = !(rst_pull || board_rst);
  // adapter overrides the board receiver through the resistor
  assign rx_pin = rx_oe ? rx_out : board_rx;
endmodule // pac_target_model

// >>> sim/pac_adapter_sva.sv
// checker for the adapter top module, bound below
// assumes a single clock and reduced sim counts
`timescale 1ns/1ps
module pac_adapter_sva #(
  parameter int unsigned RST_PULSE_CYC = pac_pkg::RST_PULSE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched pins
  input wire logic mode_toggle_button,
  input wire logic target_reset_n_in,
  input wire logic target_reset_n_oe,
  input wire logic boot_mode_select_pins_oe,
  input wire logic programming_voltage,
  input wire pac_pkg::pac_status_t status
);
  logic [31:0] pull_len; // cycles of the current pull
  // count the reset pull length
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !target_reset_n_oe) pull_len <= '0;
    else pull_len <= pull_len + 32'h0000_0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_pull;
    $rose(target_reset_n_oe);
  endsequence
  property p_sel; boot_mode_select_pins_oe == status.boot_mode; endproperty
  property p_pv; programming_voltage == status.vpp_on; endproperty
  property p_pv_n; $changed(status.vpp_on) |-> $past(status.boot_mode);
  endproperty
  property p_trc; $changed(status.route) |-> !status.boot_mode; endproperty
  property p_loop; s_pull |-> status.loop_back == status.boot_mode;
  endproperty
  property p_pull;
    $fell(target_reset_n_oe) |-> pull_len == RST_PULSE_CYC + 1;
  endproperty
  property p_hold; s_pull ##0 status.boot_mode |-> status.loop_back[*8];
  endproperty
  property p_end;
    $fell(status.loop_back) |-> target_reset_n_in && !target_reset_n_oe;
  endproperty
  property p_line; $fell(target_reset_n_in) && !target_reset_n_oe &&
    !status.loop_back |-> ##[1:8] target_reset_n_oe;
  endproperty
  // a mode change follows two low samples of the pin, four and five
  // edges earlier; later bounce on the pin is legal
  property p_rel; $changed(status.boot_mode) |->
    !$past(mode_toggle_button, 4) && !$past(mode_toggle_button, 5);
  endproperty
  property p_rst; $fell(sys_rst) |-> status == '0 && !target_reset_n_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("mode pin");
  a_pv: assert property (p_pv) else $error("vpp pin");
  a_pv_n: assert property (p_pv_n) else $error("vpp normal");
  a_trc: assert property (p_trc) else $error("route in boot");
  a_loop: assert property (p_loop) else $error("loop");
  a_pull: assert property (p_pull) else $error("pull len");
  a_hold: assert property (p_hold) else $error("loop hold");
  a_end: assert property (p_end) else $error("loop end");
  a_line: assert property (p_line) else $error("line fall");
  a_rel: assert property (p_rel) else $error("no release");
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // pac_adapter_sva
bind pac_adapter pac_adapter_sva #(.RST_PULSE_CYC(RST_PULSE_CYC)) sva_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst),
  .mode_toggle_button(mode_toggle_button),
  .target_reset_n_in(target_reset_n_in),
  .target_reset_n_oe(target_reset_n_oe),
  .boot_mode_select_pins_oe(boot_mode_select_pins_oe),
  .programming_voltage(programming_voltage), .status(status));

// >>> sim/pac_adapter_tb.sv
// testbench for the adapter: bouncy presses, serial routing, resets
// assumes short sim counts and the board model beside it
`timescale 1ns/1ps
module pac_adapter_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] btn = '0; // raw buttons by index
  logic brd_rst = 1'b0; // board pulls reset
  logic htx = 1'b1, tx = 1'b1, brx = 1'b1;
  logic rst_line, rst_oe, rx_out, rx_oe, rx_pin, host_rx, sel_oe, pv;
  logic rst_out, sel_out; // pins that must only ever drive low
  logic en = 1'b1; // clock enable
  logic seen, lb, lp; // reset pull observations
  pac_pkg::pac_status_t status, exp;
  int miscompares = 0, check_count = 0;
  int seq[10] = '{1, 1, 1, 3, 0, 2, 1, 3, 3, 0};
  pac_adapter #(.DEBOUNCE_CYC(8), .RST_PULSE_CYC(4),
    .LOOP_HOLD_CYC(8)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(en),
    .target_reset_button(btn[pac_pkg::BTN_RESET]),
    .serial_trace_button(btn[pac_pkg::BTN_TRACE]),
    .mode_toggle_button(btn[pac_pkg::BTN_MODE]),
    .prog_voltage_button(btn[pac_pkg::BTN_VPP]),
    .target_reset_n_in(rst_line), .target_reset_n_out(rst_out),
    .target_reset_n_oe(rst_oe), .boot_mode_select_pins_out(sel_out),
    .boot_mode_select_pins_oe(sel_oe), .target_transmit_pin(tx),
    .host_tx(htx), .host_rx(host_rx), .target_receive_pin_out(rx_out),
    .target_receive_pin_oe(rx_oe), .target_receive_pin_in(rx_pin),
    .programming_voltage(pv), .status(status));
  pac_target_model brd_u (.rst_pull(rst_oe), .board_rst(brd_rst),
    .rx_oe(rx_oe), .rx_out(rx_out), .board_rx(brx),
    .reset_line(rst_line), .rx_pin(rx_pin));
  // free-running clock
  initial forever #2.5 clk_sys = !clk_sys;
  // compare and count
  task chk(logic [7:0] got, logic [7:0] want);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task close_out;
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // expected state after one press
  function automatic pac_pkg::pac_status_t nxt(int b,
      pac_pkg::pac_status_t s);
    if (b == pac_pkg::BTN_MODE) s.boot_mode = !s.boot_mode;
    if (b == pac_pkg::BTN_VPP && s.boot_mode) s.vpp_on = !s.vpp_on;
    if (b == pac_pkg::BTN_TRACE && !s.boot_mode) begin
      s.route = (s.route == pac_pkg::PAC_ROUTE_THRU) ? pac_pkg::PAC_ROUTE_RX
        : pac_pkg::pac_route_t'(s.route + 2'h1);
    end
    return s;
  endfunction
  // watch a reset pull while the target talks; a board pull that is
  // under way is let go after eight cycles
  task settle;
    seen = 0;
    lp = 1;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys);
      brd_rst = brd_rst && (k < 8);
      if (rst_oe) begin
        seen = 1;
        lb = status.loop_back;
        if (lb) lp &= (rx_pin === tx);
      end
      tx = 1'($urandom);
    end
  endtask
  // bouncy press and release, then check state
  task press(int b);
    for (int i = 0; i < 25; i++) begin
      @(negedge clk_sys);
      btn[b] = (i < 4 || i > 19) ? 1'($urandom) : (i < 18);
    end
    @(negedge clk_sys) btn[b] = 1'b0;
    settle();
    exp = nxt(b, exp);
    chk({status, sel_oe, pv}, {exp, exp.boot_mode, exp.vpp_on});
    if (b == pac_pkg::BTN_RESET)
      chk({seen, lb, lp}, {1'b1, exp.boot_mode, 1'b1});
  endtask
  // random serial traffic through current routing
  task serial;
    htx = 1'($urandom);
    tx = 1'($urandom);
    brx = 1'($urandom);
    @(negedge clk_sys);
    chk(host_rx, (!exp.boot_mode && exp.route == pac_pkg::PAC_ROUTE_RX)
      ? brx : tx);
    chk(rx_pin, (exp.boot_mode || exp.route == pac_pkg::PAC_ROUTE_THRU)
      ? htx : brx);
    chk({rst_out, sel_out}, 2'h0);
  endtask
  task do_reset;
    sys_rst = 1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 0;
    exp = '0;
    chk({status, sel_oe, pv, rst_oe}, 8'h00);
  endtask
  // main sequence
  initial begin
    void'($urandom(47855));
    do_reset();
    foreach (seq[i]) begin
      press(seq[i]);
      serial();
    end
    @(negedge clk_sys) brd_rst = 1'b1; // board pulls the line itself
    settle();
    chk({seen, lb, lp}, {1'b1, exp.boot_mode, 1'b1});
    en = 1'b0; // frozen: a whole press must leave no trace
    btn[pac_pkg::BTN_MODE] = 1'b1;
    repeat (20) @(negedge clk_sys);
    btn[pac_pkg::BTN_MODE] = 1'b0;
    repeat (20) @(negedge clk_sys);
    en = 1'b1;
    settle();
    chk({status, sel_oe, pv}, {exp, exp.boot_mode, exp.vpp_on});
    repeat (30) begin
      press($urandom_range(3, 0));
      serial();
    end
    do_reset();
    press(pac_pkg::BTN_MODE);
    close_out();
  end
  // watchdog
  initial begin
    #60_000;
    miscompares++;
    close_out();
  end
endmodule // pac_adapter_tb
